// ### nic_pkg.sv
// Package holding constants, types and register layout for the nested interrupt controller.
package nic_pkg;

    // Register word offsets on the Wishbone bus.
    localparam logic [3:0] OFS_CC      = 4'h0;
    localparam logic [3:0] OFS_PRIO0   = 4'h1;
    localparam logic [3:0] OFS_PRIO1   = 4'h2;
    localparam logic [3:0] OFS_PRIO2   = 4'h3;
    localparam logic [3:0] OFS_PRIO3   = 4'h4;
    localparam logic [3:0] OFS_RSTFLAG = 4'h5;
    localparam logic [3:0] OFS_PEND    = 4'h6;
    localparam logic [3:0] OFS_ENABLE  = 4'h7;
    localparam logic [3:0] OFS_HALTCAP = 4'h8;
    localparam logic [3:0] OFS_SERVICE = 4'h9;
    localparam logic [3:0] OFS_CLRPEND = 4'ha;

    // Condition code reset value and priority bit positions.
    localparam logic [7:0] CC_RESET    = 8'hea;
    localparam int         CC_BIT_HIGH = 5;
    localparam int         CC_BIT_LOW  = 3;

    // Priority register reset value and masked-vector enable reset.
    localparam logic [7:0]  PRIO_RESET   = 8'hff;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] HALTCAP_RESET = 16'h203f;

    // Two-bit level codes: priority_bit_high, priority_bit_low.
    localparam logic [1:0] LVL0 = 2'b10;
    localparam logic [1:0] LVL1 = 2'b01;
    localparam logic [1:0] LVL2 = 2'b00;
    localparam logic [1:0] LVL3 = 2'b11;

    // Vector table: reset, trap, then the top-level vector and the maskable vectors downward.
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_TRAP  = 16'hfffc;
    localparam logic [15:0] VEC_BASE0 = 16'hfffa;
    localparam logic [15:0] VEC_TOP   = 16'hffe0;
    localparam int          NUM_VEC   = 14;
    localparam int          TLI_IDX   = 0;

    // Service request to the core.
    typedef struct packed {
        logic        valid;
        logic [15:0] vector;
        logic [1:0]  level;
        logic        stack;
    } entry_s;

    // Wishbone slave request.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [7:0]  dat;
    } wb_req_s;

endpackage : nic_pkg

// ### nested_interrupt_controller.sv
// Nested four-level-priority interrupt controller with reset cause flags and Wishbone access.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none

module nested_interrupt_controller #(
    parameter int NVEC = nic_pkg::NUM_VEC
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            pin_reset_i,
    input  wire logic            wdg_reset_i,
    input  wire logic            supply_drop_reset_i,
    input  wire logic            tli_pin_i,
    input  wire logic [NVEC-1:0] edge_src_i,
    input  wire logic [NVEC-1:0] periph_flag_i,
    input  wire logic [NVEC-1:0] periph_clear_i,
    input  wire logic            instr_done_i,
    input  wire logic            trap_i,
    input  wire logic            return_from_interrupt_i,
    input  wire logic [7:0]      return_from_interrupt_cc_i,
    input  wire logic            cc_write_i,
    input  wire logic [7:0]      cc_wdata_i,
    input  wire logic            halted_i,
    input  wire logic            waiting_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [3:0]      wb_adr_i,
    input  wire logic [7:0]      wb_dat_i,
    output logic [7:0]           wb_dat_o,
    output logic                 wb_ack_o,
    output logic                 entry_valid_o,
    output logic [15:0]          entry_vector_o,
    output logic                 entry_stack_o,
    output logic                 wake_o,
    output logic [7:0]           cc_o
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and nets.
    logic [7:0]      cc_r;
    logic [7:0]      prio_r [4];
    logic [NVEC-1:0] pend_r;
    logic [NVEC-1:0] enable_r;
    logic [NVEC-1:0] haltcap_r;
    logic            wdg_flag_r;
    logic            supply_flag_r;
    logic [2:0]      tli_sync_r;
    logic            tli_level_r;
    logic [NVEC-1:0] edge_prev_r;
    logic            trap_pend_r;
    logic            wb_ack_r;
    logic [7:0]      wb_dat_r;
    nic_pkg::entry_s entry_r;
    logic            wake_r;
    logic            halt_exit_r;
    logic            wb_wr;
    logic [1:0]      cur_lvl;
    logic [NVEC-1:0] raw_req;
    nic_pkg::entry_s pick;
    logic [2:0]      best_rank;
    logic [2:0]      rank;
    logic [1:0]      vlvl;
    logic            tli_rise;
    logic            trap_take;
    logic            pick_take;

    // Bus writes land at the edge where the master samples ack high.
    assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_r;
    assign cur_lvl = {cc_r[nic_pkg::CC_BIT_HIGH], cc_r[nic_pkg::CC_BIT_LOW]};
    assign tli_rise = tli_sync_r[2] && tli_sync_r[1] && !tli_level_r;

    // A pending trap yields only to the top-level request; entry and latch clears share this.
    assign trap_take = instr_done_i && trap_pend_r &&
                       !(pick.valid && pick.vector == nic_pkg::VEC_BASE0);
    assign pick_take = instr_done_i && pick.valid && !trap_take;

    // Maps a two-bit level code onto a numeric rank 0..3.
    function automatic logic [2:0] lvl_rank(input logic [1:0] code);
        logic [2:0] r;
        r = 3'h0;
        case (code)
            nic_pkg::LVL0: r = 3'h0;
            nic_pkg::LVL1: r = 3'h1;
            nic_pkg::LVL2: r = 3'h2;
            default:       r = 3'h3;
        endcase
        return r;
    endfunction : lvl_rank

    ////////////////////////////////////////////////////////////////////////
    // Reset cause flags; the supply flag is never cleared by other resets.
    always_ff @(posedge clk_i) begin
        if (supply_drop_reset_i) begin
            supply_flag_r <= 1'b1;
            wdg_flag_r    <= 1'b0;
        end else if (wdg_reset_i) begin
            wdg_flag_r <= 1'b1;
        end else if (pin_reset_i && !supply_flag_r) begin
            wdg_flag_r <= 1'b0;
        end else if (wb_wr && wb_adr_i == nic_pkg::OFS_RSTFLAG) begin
            if (!wb_dat_i[0]) begin
                wdg_flag_r <= 1'b0;
            end
            if (!wb_dat_i[1]) begin
                supply_flag_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Top-level pin passes three flops; a rise counts when stages two and three agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tli_sync_r  <= 3'h0;
            tli_level_r <= 1'b0;
        end else begin
            tli_sync_r <= {tli_sync_r[1:0], tli_pin_i};
            if (tli_sync_r[2] == tli_sync_r[1]) begin
                tli_level_r <= tli_sync_r[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector priority registers; level-0 code fields keep their old value.
    for (genvar g = 0; g < 4; g++) begin : g_prio
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                prio_r[g] <= nic_pkg::PRIO_RESET;
            end else if (wb_wr && wb_adr_i == nic_pkg::OFS_PRIO0 + 4'(g)) begin
                for (int f = 0; f < 4; f++) begin
                    if (wb_dat_i[2*f+:2] != nic_pkg::LVL0 && !(g == 3 && f >= 2)) begin
                        prio_r[g][2*f+:2] <= wb_dat_i[2*f+:2];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request latches: edge or flag sets, entry or clear sequence drops.
    always_comb begin
        raw_req = '0;
        for (int i = 0; i < NVEC; i++) begin
            raw_req[i] = (edge_src_i[i] && !edge_prev_r[i]) || periph_flag_i[i];
        end
        raw_req[nic_pkg::TLI_IDX] = tli_rise;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r      <= '0;
            edge_prev_r <= '0;
        end else begin
            edge_prev_r <= edge_src_i;
            for (int i = 0; i < NVEC; i++) begin
                if (raw_req[i]) begin
                    pend_r[i] <= 1'b1;
                end else if (periph_clear_i[i]) begin
                    pend_r[i] <= 1'b0;
                end else if (pick_take && pick.vector == nic_pkg::VEC_BASE0 - 16'(2*i)) begin
                    pend_r[i] <= 1'b0;
                end else if (wb_wr && wb_adr_i == nic_pkg::OFS_CLRPEND && i < 8 &&
                             wb_dat_i[i%8]) begin
                    pend_r[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbitration: software level first, then lowest index wins ties.
    always_comb begin
        pick      = '0;
        best_rank = 3'h0;
        rank      = 3'h0;
        vlvl      = 2'b00;
        for (int i = NVEC - 1; i >= 0; i--) begin
            vlvl = prio_r[i/4][2*(i%4)+:2];
            rank = (i == nic_pkg::TLI_IDX) ? 3'h4 : lvl_rank(vlvl);
            if (pend_r[i] && (enable_r[i] || i == nic_pkg::TLI_IDX) &&
                rank > lvl_rank(cur_lvl) &&
                (!halt_exit_r || haltcap_r[i]) &&
                (!pick.valid || rank >= best_rank)) begin
                best_rank    = rank;
                pick.valid   = 1'b1;
                pick.vector  = nic_pkg::VEC_BASE0 - 16'(2*i);
                pick.level   = (i == nic_pkg::TLI_IDX) ? nic_pkg::LVL3 : vlvl;
                pick.stack   = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trap latch; the top-level request may still preempt it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trap_pend_r <= 1'b0;
        end else if (trap_i) begin
            trap_pend_r <= 1'b1;
        end else if (trap_take) begin
            trap_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry strobe to the core and condition code level updates.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            entry_r <= '{valid: 1'b1, vector: nic_pkg::VEC_RESET,
                         level: nic_pkg::LVL3, stack: 1'b0};
            cc_r    <= nic_pkg::CC_RESET;
        end else begin
            entry_r.valid <= 1'b0;
            if (trap_take) begin
                entry_r <= '{valid: 1'b1, vector: nic_pkg::VEC_TRAP,
                             level: nic_pkg::LVL3, stack: 1'b1};
                cc_r[nic_pkg::CC_BIT_HIGH] <= 1'b1;
                cc_r[nic_pkg::CC_BIT_LOW]  <= 1'b1;
            end else if (pick_take) begin
                entry_r <= pick;
                cc_r[nic_pkg::CC_BIT_HIGH] <= pick.level[1];
                cc_r[nic_pkg::CC_BIT_LOW]  <= pick.level[0];
            end else if (return_from_interrupt_i) begin
                cc_r <= return_from_interrupt_cc_i;
            end else if (cc_write_i) begin
                cc_r <= cc_wdata_i;
            end else if (wb_wr && wb_adr_i == nic_pkg::OFS_CC) begin
                cc_r <= wb_dat_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake: any pending request ends wait; halt needs halt-capable ones.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_r      <= 1'b0;
            halt_exit_r <= 1'b0;
        end else begin
            wake_r <= (waiting_i && (|pend_r || trap_pend_r)) ||
                      (halted_i && |(pend_r & haltcap_r));
            if (halted_i) begin
                halt_exit_r <= 1'b1;
            end else if (entry_r.valid) begin
                halt_exit_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable and halt capability masks.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r  <= NVEC'(nic_pkg::ENABLE_RESET);
            haltcap_r <= NVEC'(nic_pkg::HALTCAP_RESET);
        end else if (wb_wr && wb_adr_i == nic_pkg::OFS_ENABLE) begin
            enable_r[7:0] <= wb_dat_i;
        end else if (wb_wr && wb_adr_i == nic_pkg::OFS_HALTCAP) begin
            haltcap_r[7:0] <= wb_dat_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-cycle ack, unmapped reads return zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 8'h00;
        end else begin
            wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
            if (wb_adr_i == nic_pkg::OFS_CC) begin
                wb_dat_r <= cc_r;
            end else if (wb_adr_i >= nic_pkg::OFS_PRIO0 && wb_adr_i <= nic_pkg::OFS_PRIO3) begin
                wb_dat_r <= prio_r[2'(wb_adr_i - nic_pkg::OFS_PRIO0)];
            end else if (wb_adr_i == nic_pkg::OFS_RSTFLAG) begin
                wb_dat_r <= {6'h00, supply_flag_r, wdg_flag_r};
            end else if (wb_adr_i == nic_pkg::OFS_PEND) begin
                wb_dat_r <= pend_r[7:0];
            end else if (wb_adr_i == nic_pkg::OFS_ENABLE) begin
                wb_dat_r <= enable_r[7:0];
            end else if (wb_adr_i == nic_pkg::OFS_HALTCAP) begin
                wb_dat_r <= haltcap_r[7:0];
            end else if (wb_adr_i == nic_pkg::OFS_SERVICE) begin
                wb_dat_r <= entry_r.vector[7:0];
            end else begin
                wb_dat_r <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops.
    assign wb_ack_o       = wb_ack_r;
    assign wb_dat_o       = wb_dat_r;
    assign entry_valid_o  = entry_r.valid;
    assign entry_vector_o = entry_r.vector;
    assign entry_stack_o  = entry_r.stack;
    assign wake_o         = wake_r;
    assign cc_o           = cc_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks beside the logic.
    sequence s_supply_drop;
        supply_drop_reset_i;
    endsequence

    a_supply_flag_set: assert property (@(posedge clk_i)
        s_supply_drop |=> supply_flag_r && !wdg_flag_r) else $error("supply flag not recorded");

    a_wdg_flag_set: assert property (@(posedge clk_i)
        wdg_reset_i && !supply_drop_reset_i |=> wdg_flag_r) else $error("watchdog flag not set");

    a_prio_reset: assert property (@(posedge clk_i)
        rst_i |=> prio_r[0] == nic_pkg::PRIO_RESET) else $error("priority reset wrong");

    a_lvl0_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_wr && wb_adr_i == nic_pkg::OFS_PRIO0 && wb_dat_i[1:0] == nic_pkg::LVL0
        |=> prio_r[0][1:0] == $past(prio_r[0][1:0])) else $error("level 0 written");

    a_entry_level: assert property (@(posedge clk_i) disable iff (rst_i)
        instr_done_i && pick.valid && !trap_pend_r
        |=> entry_r.valid && cur_lvl == $past(pick.level)) else $error("entry level wrong");

    a_trap_level: assert property (@(posedge clk_i) disable iff (rst_i)
        entry_r.valid && entry_r.vector == nic_pkg::VEC_TRAP |-> cur_lvl == nic_pkg::LVL3)
        else $error("trap level not 3");

    a_return_from_interrupt_restore: assert property (@(posedge clk_i) disable iff (rst_i)
        return_from_interrupt_i && !trap_take && !pick_take |=> cc_r == $past(return_from_interrupt_cc_i))
        else $error("return_from_interrupt restore");

    a_mask_block: assert property (@(posedge clk_i) disable iff (rst_i)
        cur_lvl == nic_pkg::LVL3 && pick.valid |-> pick.vector == nic_pkg::VEC_BASE0)
        else $error("masked request picked");

    a_tli_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        tli_rise |=> pend_r[nic_pkg::TLI_IDX]) else $error("top-level not latched");

    a_tli_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        pend_r[nic_pkg::TLI_IDX] && !halt_exit_r
        |-> pick.valid && pick.vector == nic_pkg::VEC_BASE0) else $error("top-level not chosen");

    a_trap_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        trap_take |=> entry_r.valid && entry_r.vector == nic_pkg::VEC_TRAP && entry_r.stack)
        else $error("trap entry wrong");

endmodule : nested_interrupt_controller
`default_nettype wire

// ### core_model.sv
// Behavioural model of the processor core that consumes service entries.
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] cmd_i,
    input  wire logic       slow_i,
    input  wire logic       entry_valid_i,
    input  wire logic       entry_stack_i,
    input  wire logic       wake_i,
    input  wire logic [7:0] cc_i,
    output logic            instr_done_o = 1'h0,
    output logic            trap_o       = 1'h0,
    output logic            return_from_interrupt_o       = 1'h0,
    output logic [7:0]      return_from_interrupt_cc_o    = 8'h00,
    output logic            cc_write_o   = 1'h0,
    output logic [7:0]      cc_wdata_o   = 8'h00,
    output logic            halted_o     = 1'h0,
    output logic            waiting_o    = 1'h0
);
    logic [7:0] stack_q[$];
    logic [7:0] prev_cc_r = 8'h00;
    logic [2:0] gap_r     = 3'h0;
    ////////////////////////////////////////
    // Commands 1..5 are enable, return, trap, halt and wait.
    // Data lines not qualified by a strobe toggle so stale values never match.
    always @(posedge clk_i) begin
        prev_cc_r  <= cc_i;
        trap_o     <= 1'h0;
        return_from_interrupt_o     <= 1'h0;
        cc_write_o <= 1'h0;
        return_from_interrupt_cc_o  <= ~return_from_interrupt_cc_o;
        cc_wdata_o <= ~cc_wdata_o;
        gap_r      <= (gap_r == 3'h0) ? (slow_i ? 3'h7 : 3'h0) : gap_r - 3'h1;
        instr_done_o <= (gap_r == 3'h0) && !halted_o && !waiting_o && !rst_i;
        if (rst_i) begin
            stack_q.delete();
            halted_o  <= 1'h0;
            waiting_o <= 1'h0;
        end else begin
            if (entry_valid_i && entry_stack_i) begin
                stack_q.push_back(prev_cc_r);
            end
            if (wake_i) begin
                halted_o  <= 1'h0;
                waiting_o <= 1'h0;
            end
            if (cmd_i == 3'h1 || cmd_i == 3'h4 || cmd_i == 3'h5) begin
                cc_write_o <= 1'h1;
                cc_wdata_o <= (cc_i & 8'hf7) | 8'h20;
            end
            if (cmd_i == 3'h2 && stack_q.size() > 0) begin
                return_from_interrupt_o    <= 1'h1;
                return_from_interrupt_cc_o <= stack_q.pop_back();
            end
            trap_o <= (cmd_i == 3'h3);
            if (cmd_i == 3'h4) begin
                halted_o <= 1'h1;
            end
            if (cmd_i == 3'h5) begin
                waiting_o <= 1'h1;
            end
        end
    end
endmodule : core_model
`default_nettype wire

// ### test_nested_interrupt_controller.sv
// Self-checking testbench for the nested interrupt controller.
`timescale 1ns/10ps
`default_nettype none
module test_nested_interrupt_controller;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic [2:0]  cause = 3'h1;
    logic        tli_pin_i = 1'h0;
    logic [13:0] drv [3] = '{default: 14'h0};
    logic        wb_cyc_i = 1'h0;
    logic        wb_stb_i = 1'h0;
    logic        wb_we_i = 1'h0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [7:0]  wb_dat_i = 8'h00;
    logic [7:0]  wb_dat_o, cc_o, return_from_interrupt_cc, cc_wdata;
    logic [15:0] entry_vector_o;
    logic        wb_ack_o, entry_valid_o, entry_stack_o, wake_o;
    logic        instr_done, trap, return_from_interrupt, cc_write, halted, waiting;
    logic [2:0]  cmd = 3'h0;
    logic        slow = 1'h0;
    logic [7:0]  prio [4] = '{default: 8'hff};
    int          mismatches = 0;
    int          n_checks = 0;
    int          cycles = 0;

    nested_interrupt_controller i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .pin_reset_i(cause[0]), .wdg_reset_i(cause[1]), .supply_drop_reset_i(cause[2]),
        .tli_pin_i(tli_pin_i), .edge_src_i(drv[0]), .periph_flag_i(drv[1]),
        .periph_clear_i(drv[2]), .instr_done_i(instr_done), .trap_i(trap), .return_from_interrupt_i(return_from_interrupt),
        .return_from_interrupt_cc_i(return_from_interrupt_cc), .cc_write_i(cc_write), .cc_wdata_i(cc_wdata),
        .halted_i(halted), .waiting_i(waiting), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .entry_valid_o(entry_valid_o), .entry_vector_o(entry_vector_o),
        .entry_stack_o(entry_stack_o), .wake_o(wake_o), .cc_o(cc_o));
    core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .slow_i(slow),
        .entry_valid_i(entry_valid_o), .entry_stack_i(entry_stack_o), .wake_i(wake_o),
        .cc_i(cc_o), .instr_done_o(instr_done), .trap_o(trap), .return_from_interrupt_o(return_from_interrupt),
        .return_from_interrupt_cc_o(return_from_interrupt_cc), .cc_write_o(cc_write), .cc_wdata_o(cc_wdata),
        .halted_o(halted), .waiting_o(waiting));
    ////////////////////////////////////////
    // Clock at 40 MHz and a hang guard far above the expected run length.
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check

    function automatic logic [1:0] code(input int l);
        return (l == 0) ? 2'h2 : (l == 1) ? 2'h1 : (l == 2) ? 2'h0 : 2'h3;
    endfunction : code

    function automatic logic [15:0] vaddr(input int i);
        return 16'hfffa - 16'(2 * i);
    endfunction : vaddr

    // Classic single cycle: hold everything until ack is sampled, then release.
    task automatic wb(input logic [3:0] a, input logic we, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 40);
        q = wb_dat_o;
        if (n >= 40) mismatches++;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(a, 1'h1, d, q);
    endtask : wr

    task automatic rd_chk(input string w, input logic [3:0] a, input logic [7:0] e,
                          input logic [7:0] m = 8'hff);
        logic [7:0] q;
        wb(a, 1'h0, 8'h00, q);
        check(w, {8'h00, e & m}, {8'h00, q & m});
    endtask : rd_chk

    task automatic core(input logic [2:0] c);
        @(posedge clk_i);
        cmd <= c;
        @(posedge clk_i);
        cmd <= 3'h0;
    endtask : core

    task automatic lvl_chk(input logic [1:0] e);
        repeat (3) @(posedge clk_i);
        check("level", {14'h0, e}, {14'h0, cc_o[5], cc_o[3]});
    endtask : lvl_chk

    task automatic pulse(input int s, input logic [13:0] m);
        @(posedge clk_i);
        drv[s] <= m;
        @(posedge clk_i);
        drv[s] <= 14'h0;
    endtask : pulse

    task automatic set_lvl(input int i, input int l);
        prio[i / 4][2 * (i % 4) +: 2] = code(l);
        wr(nic_pkg::OFS_PRIO0 + 4'(i / 4), prio[i / 4]);
    endtask : set_lvl

    task automatic do_reset(input logic [2:0] c);
        @(posedge clk_i);
        rst_i <= 1'h1;
        cause <= c;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        cause <= 3'h0;
    endtask : do_reset

    task automatic expect_entry(input logic [15:0] v, input logic [1:0] l);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (entry_valid_o !== 1'h1 && n < 200);
        if (n >= 200) mismatches++;
        check("vector", v, entry_vector_o);
        check("level", {14'h0, l}, {14'h0, cc_o[5], cc_o[3]});
        check("stacked", 16'h1, {15'h0, entry_stack_o});
    endtask : expect_entry
    ////////////////////////////////////////
    // Main sequence: registers, reset causes, then nesting scenarios.
    initial begin
        int a, b, la, lb, w;
        logic [2:0] st [10] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h0, 3'h2, 3'h4, 3'h2, 3'h1, 3'h0};
        logic [1:0] fe [10] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h0};
        logic [1:0] fm [10] = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3};
        void'($urandom(32'h539d));
        repeat (20) @(posedge clk_i);
        check("reset vector", nic_pkg::VEC_RESET, entry_vector_o);
        check("reset stack", 16'h0, {15'h0, entry_stack_o});
        check("reset cc", {8'h00, nic_pkg::CC_RESET}, {8'h00, cc_o});
        rst_i <= 1'h0;
        cause <= 3'h0;
        for (int k = 0; k < 4; k++) begin
            rd_chk("priority", nic_pkg::OFS_PRIO0 + 4'(k), 8'hff);
        end
        rd_chk("halt capable", nic_pkg::OFS_HALTCAP, 8'h3f);
        wr(4'hf, 8'h5a);
        rd_chk("unmapped", 4'hf, 8'h00);
        wr(nic_pkg::OFS_PRIO1, 8'hcf);
        wr(nic_pkg::OFS_PRIO1, 8'h64);
        rd_chk("level 0 write", nic_pkg::OFS_PRIO1, 8'h44);
        for (int k = 0; k < 10; k++) begin
            if (st[k] == 3'h0) wr(nic_pkg::OFS_RSTFLAG, 8'h00);
            else do_reset(st[k]);
            rd_chk("flags", nic_pkg::OFS_RSTFLAG, {6'h0, fe[k]}, {6'h0, fm[k]});
        end
        core(3'h1);
        lvl_chk(2'h2);
        a = $urandom_range(7, 1);
        la = $urandom_range(3, 1);
        set_lvl(a, la);
        pulse(0, 14'(1 << a));
        rd_chk("pending", nic_pkg::OFS_PEND, 8'(1 << a), 8'(1 << a));
        wr(nic_pkg::OFS_ENABLE, 8'(1 << a));
        expect_entry(vaddr(a), code(la));
        rd_chk("pending", nic_pkg::OFS_PEND, 8'h00, 8'(1 << a));
        rd_chk("service", nic_pkg::OFS_SERVICE, 8'(vaddr(a)));
        core(3'h2);
        lvl_chk(2'h2);
        wr(nic_pkg::OFS_ENABLE, 8'hfe);
        for (int k = 0; k < 6; k++) begin
            a = (k == 0) ? 5 : $urandom_range(7, 1);
            b = (k == 0) ? 2 : (a % 7) + 1;
            la = (k == 0) ? 1 : $urandom_range(3, 1);
            lb = (k == 0) ? 1 : $urandom_range(3, 1);
            slow <= 1'($urandom_range(1));
            set_lvl(a, la);
            set_lvl(b, lb);
            pulse(0, 14'((1 << a) | (1 << b)));
            w = (la != lb) ? ((la > lb) ? a : b) : ((a < b) ? a : b);
            expect_entry(vaddr(w), code((w == a) ? la : lb));
            core(3'h2);
            expect_entry(vaddr(a + b - w), code((w == a) ? lb : la));
            core(3'h2);
        end
        slow <= 1'h0;
        core(3'h3);
        expect_entry(nic_pkg::VEC_TRAP, 2'h3);
        @(posedge clk_i);
        tli_pin_i <= 1'h1;
        expect_entry(vaddr(0), 2'h3);
        tli_pin_i <= 1'h0;
        core(3'h2);
        lvl_chk(2'h3);
        core(3'h2);
        lvl_chk(2'h2);
        tli_pin_i <= 1'h1;
        expect_entry(vaddr(0), 2'h3);
        tli_pin_i <= 1'h0;
        core(3'h2);
        set_lvl(7, 1);
        core(3'h5);
        pulse(0, 14'h80);
        expect_entry(vaddr(7), 2'h1);
        core(3'h2);
        set_lvl(2, 1);
        set_lvl(7, 2);
        core(3'h4);
        pulse(0, 14'h80);
        repeat (10) @(posedge clk_i);
        check("halted", 16'h1, {15'h0, halted});
        check("wake", 16'h0, {15'h0, wake_o});
        pulse(0, 14'h04);
        expect_entry(vaddr(2), 2'h1);
        expect_entry(vaddr(7), 2'h0);
        core(3'h2);
        core(3'h2);
        lvl_chk(2'h2);
        wr(nic_pkg::OFS_ENABLE, 8'h00);
        pulse(1, 14'h08);
        rd_chk("pending", nic_pkg::OFS_PEND, 8'h08, 8'h08);
        pulse(2, 14'h08);
        rd_chk("pending", nic_pkg::OFS_PEND, 8'h00, 8'h08);
        pulse(0, 14'h10);
        wr(nic_pkg::OFS_CLRPEND, 8'h10);
        rd_chk("pending", nic_pkg::OFS_PEND, 8'h00, 8'h10);
        tally_and_finish();
    end
endmodule : test_nested_interrupt_controller
`default_nettype wire
